// ===== logic/phd_map.vh
/*
 Constants of the parameter header store: register offsets, field
 positions, status bits and reset values. Definitions only; included
 by bare name from the design file.
*/
`ifndef PHD_MAP_VH
`define PHD_MAP_VH

// Register offsets on the plain register port
`define PHD_REG_CTRL 8'h00
`define PHD_REG_INDEX 8'h04
`define PHD_REG_DW0 8'h08
`define PHD_REG_DW1 8'h0c
`define PHD_REG_COUNT 8'h10
`define PHD_REG_STATUS 8'h14
`define PHD_REG_MASK 8'h18

// Control bits
`define PHD_CTRL_SERVE 0
`define PHD_CTRL_WIPE 1

// Status and mask bits
`define PHD_ST_COMMIT 0
`define PHD_ST_REJECT 1
`define PHD_ST_ORDER 2
`define PHD_ST_GAP 3
`define PHD_ST_RANGE 4
`define PHD_ST_W 5

// Fault code bits
`define PHD_F_ID 0
`define PHD_F_PARITY 1
`define PHD_F_ALIGN 2
`define PHD_F_MAJOR 3
`define PHD_F_LEN 4
`define PHD_F_FIRST 5
`define PHD_F_W 6

// Header layout in the discovery space
`define PHD_HDR_BASE 24'h000008
`define PHD_LEN_HI 31
`define PHD_LEN_LO 24
`define PHD_MAJ_HI 23
`define PHD_MAJ_LO 16
`define PHD_MIN_HI 15
`define PHD_MIN_LO 8
`define PHD_IDL_HI 7
`define PHD_IDL_LO 0
`define PHD_IDH_HI 31
`define PHD_IDH_LO 24
`define PHD_PTR_HI 23
`define PHD_PTR_LO 0

// Identifier values
`define PHD_ID_BASIC_LSB 8'h00
`define PHD_ID_BASIC_MSB 8'hff
`define PHD_ID_NONE_MSB 8'h00

// Reset values
`define PHD_CTRL_RST 2'h0
`define PHD_MASK_RST 5'h00

`endif

// ===== logic/phd_header_store.v
/*
 Parameter header store of a serial flash discovery structure: holds a
 contiguous list of two-word headers, checks each one as software writes
 it, and serves the headers to the discovery read path.
 Assumes the register port and the discovery read port are driven by
 logic on clk; one clock, synchronous active-high reset.
*/
// Local design decisions: the address map and strobed register access.
// Operation
// R1: Each header is two 32-bit words, 64 bits, in the discovery space.
// R2: The first header is mandatory, a standard one, and sits at byte 08h.
// R3: Headers of several basic table revisions go oldest first.
// R4: Later headers follow with no gap and use the same two-word layout.
// R5: A later minor revision may share a start address with a longer length.
// R6: Word 0 bits 31:24 hold the table length in words, counted from one.
// R7: Word 0 bits 23:16 hold the major revision, which starts at 01h.
// R8: Word 0 bits 15:8 hold the minor revision, which starts at 00h.
// R9: The id low byte is word 0 bits 7:0, the high byte word 1 bits 31:24.
// R10: Word 1 bits 23:0 give the table byte address, a multiple of four.
// R11: The host classes tables by id high byte range and low byte parity.
// R12: Low id byte 00h is the basic table and pairs only with high byte FFh.
// R13: The host takes any id with low byte 00h as the basic table.
// R14: The host reads a vendor high byte as a bank number; 00h is invalid.
// R15: The host reads odd low byte parity as vendor, even as function.
// R16: A standard high byte with an odd parity low byte is never presented.
// R17: The host flags illegal ids, misaligned pointers and zero majors.
`timescale 1ns/10ps
`include "phd_map.vh"

module phd_header_store #(
   parameter IDX_W = 2
) (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire [7:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdData,
   input wire [23:0] discAddr,
   input wire discRead,
   output reg [31:0] discData,
   output reg discValid,
   output reg irq
);

   localparam HDR_NUM = 1 << IDX_W;
   localparam CNT_W = IDX_W + 1;

   // Header fields checked before a header may be presented
   function [`PHD_F_W-1:0] hdrFault;
      input [31:0] d0;
      input [31:0] d1;
      input isFirst;
      reg [7:0] lo;
      reg [7:0] hi;
      begin
         lo = d0[`PHD_IDL_HI:`PHD_IDL_LO];
         hi = d1[`PHD_IDH_HI:`PHD_IDH_LO];
         hdrFault[`PHD_F_ID] = (lo == `PHD_ID_BASIC_LSB &&
            hi != `PHD_ID_BASIC_MSB) || hi == `PHD_ID_NONE_MSB; // R12
         hdrFault[`PHD_F_PARITY] = hi[7] & (^lo); // R16
         hdrFault[`PHD_F_ALIGN] = d1[1:0] != 2'h0; // R10
         hdrFault[`PHD_F_MAJOR] =
            d0[`PHD_MAJ_HI:`PHD_MAJ_LO] == 8'h00; // R7
         hdrFault[`PHD_F_LEN] = d0[`PHD_LEN_HI:`PHD_LEN_LO] == 8'h00; // R6
         hdrFault[`PHD_F_FIRST] = isFirst &&
            (lo != `PHD_ID_BASIC_LSB || hi != `PHD_ID_BASIC_MSB); // R2
      end
   endfunction

   // Revision key: major above minor, so a later minor ranks higher
   function [15:0] revKey;
      input [31:0] d0;
      begin
         revKey = {d0[`PHD_MAJ_HI:`PHD_MAJ_LO],
            d0[`PHD_MIN_HI:`PHD_MIN_LO]}; // R8
      end
   endfunction

   // Basic table test on a stored pair
   function isBasic;
      input [31:0] d0;
      input [31:0] d1;
      begin
         isBasic = d0[`PHD_IDL_HI:`PHD_IDL_LO] == `PHD_ID_BASIC_LSB &&
            d1[`PHD_IDH_HI:`PHD_IDH_LO] == `PHD_ID_BASIC_MSB;
      end
   endfunction

   reg [31:0] dw0Mem [0:HDR_NUM-1]; // R1
   reg [31:0] dw1Mem [0:HDR_NUM-1]; // R1
   reg [1:0] ctrl_reg;
   reg [IDX_W-1:0] index_reg;
   reg [31:0] stage_reg;
   reg [CNT_W-1:0] count_reg;
   reg [CNT_W-1:0] count_next;
   reg [`PHD_ST_W-1:0] status_reg;
   reg [`PHD_ST_W-1:0] status_next;
   reg [`PHD_ST_W-1:0] mask_reg;

   wire commitTry = regWr && regAddr == `PHD_REG_DW1;
   wire [CNT_W-1:0] indexWide = {1'b0, index_reg};
   wire [`PHD_F_W-1:0] fault =
      hdrFault(stage_reg, regWrData, index_reg == {IDX_W{1'b0}});
   wire gapBad = indexWide > count_reg; // R4
   wire [15:0] newRev = revKey(stage_reg); // R8
   wire newBasic = isBasic(stage_reg, regWrData);

   // Revision order among basic table headers
   reg orderBad;
   integer i;
   always @* begin
      orderBad = 1'b0;
      for (i = 0; i < HDR_NUM; i = i + 1) begin
         if (newBasic && i < count_reg && isBasic(dw0Mem[i], dw1Mem[i])) begin
            if (i < index_reg && revKey(dw0Mem[i]) > newRev) begin
               orderBad = 1'b1; // R3
            end
            if (i > index_reg && revKey(dw0Mem[i]) < newRev) begin
               orderBad = 1'b1; // R3
            end
         end
      end
   end

   // Start addresses are not compared, so revisions may share one
   wire commitOk = commitTry && fault == {`PHD_F_W{1'b0}} &&
      !gapBad && !orderBad; // R5

   // Discovery address decode
   wire [23:0] discOff = discAddr - `PHD_HDR_BASE; // R2
   wire [20:0] discEnt = discOff[23:3];
   wire discIn = discAddr >= `PHD_HDR_BASE &&
      discEnt < {{(21-CNT_W){1'b0}}, count_reg} &&
      ctrl_reg[`PHD_CTRL_SERVE]; // R4
   wire [IDX_W-1:0] discIdx = discEnt[IDX_W-1:0];

   // Header count field of the discovery header counts from zero,
   // so an empty list and a single header both read as zero there;
   // the raw count beside it tells the two apart
   wire [7:0] countField = (count_reg == {CNT_W{1'b0}}) ? 8'h00 :
      {{(8-CNT_W){1'b0}}, count_reg - {{(CNT_W-1){1'b0}}, 1'b1}};

   always @* begin
      count_next = count_reg;
      if (regWr && regAddr == `PHD_REG_CTRL &&
         regWrData[`PHD_CTRL_WIPE]) begin
         count_next = {CNT_W{1'b0}};
      end else if (commitOk && indexWide == count_reg) begin
         count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // R4
      end
   end

   // Sticky events; a new event wins over the read that clears
   always @* begin
      status_next = status_reg;
      if (regRd && regAddr == `PHD_REG_STATUS) begin
         status_next = {`PHD_ST_W{1'b0}};
      end
      if (commitOk) begin
         status_next[`PHD_ST_COMMIT] = 1'b1;
      end
      if (commitTry && fault != {`PHD_F_W{1'b0}}) begin
         status_next[`PHD_ST_REJECT] = 1'b1; // R16
      end
      if (commitTry && orderBad) begin
         status_next[`PHD_ST_ORDER] = 1'b1;
      end
      if (commitTry && gapBad) begin
         status_next[`PHD_ST_GAP] = 1'b1;
      end
      if (discRead && !discIn) begin
         status_next[`PHD_ST_RANGE] = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= `PHD_CTRL_RST;
         index_reg <= {IDX_W{1'b0}};
         stage_reg <= 32'h00000000;
         count_reg <= {CNT_W{1'b0}};
         status_reg <= {`PHD_ST_W{1'b0}};
         mask_reg <= `PHD_MASK_RST;
         irq <= 1'b0;
      end else if (ce) begin
         count_reg <= count_next;
         status_reg <= status_next;
         irq <= |(status_next & mask_reg);
         if (regWr) begin
            case (regAddr)
               `PHD_REG_CTRL: begin
                  ctrl_reg <= {1'b0, regWrData[`PHD_CTRL_SERVE]};
               end
               `PHD_REG_INDEX: begin
                  index_reg <= regWrData[IDX_W-1:0];
               end
               `PHD_REG_DW0: begin
                  stage_reg <= regWrData;
               end
               `PHD_REG_MASK: begin
                  mask_reg <= regWrData[`PHD_ST_W-1:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Header storage, written only by an accepted commit; not reset,
   // since a zero count hides every stale entry from the discovery port
   always @(posedge clk) begin
      if (ce && !reset && commitOk) begin
         dw0Mem[index_reg] <= stage_reg; // R6
         dw1Mem[index_reg] <= regWrData; // R9
      end
   end

   // Register read, data in the following cycle only
   always @(posedge clk) begin
      if (reset) begin
         regRdData <= 32'h00000000;
      end else if (ce) begin
         regRdData <= 32'h00000000;
         if (regRd) begin
            case (regAddr)
               `PHD_REG_CTRL: begin
                  regRdData <= {30'h00000000, ctrl_reg};
               end
               `PHD_REG_INDEX: begin
                  regRdData <= {{(32-IDX_W){1'b0}}, index_reg};
               end
               `PHD_REG_DW0: begin
                  regRdData <= dw0Mem[index_reg];
               end
               `PHD_REG_DW1: begin
                  regRdData <= dw1Mem[index_reg];
               end
               `PHD_REG_COUNT: begin
                  regRdData <= {16'h0000, countField,
                     {(8-CNT_W){1'b0}}, count_reg};
               end
               `PHD_REG_STATUS: begin
                  regRdData <= {{(32-`PHD_ST_W){1'b0}}, status_reg};
               end
               `PHD_REG_MASK: begin
                  regRdData <= {{(32-`PHD_ST_W){1'b0}}, mask_reg};
               end
               default: begin
                  regRdData <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // Discovery read, one cycle latency, zero outside the list
   always @(posedge clk) begin
      if (reset) begin
         discData <= 32'h00000000;
         discValid <= 1'b0;
      end else if (ce) begin
         discValid <= discRead;
         discData <= 32'h00000000;
         if (discRead && discIn) begin
            if (discOff[2]) begin
               discData <= dw1Mem[discIdx]; // R9
            end else begin
               discData <= dw0Mem[discIdx]; // R1
            end
         end
      end
   end

endmodule

// ===== tb/phd_asserts.sv
/*
 Port checker for phd_header_store.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module phd_asserts (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire [7:0] regAddr,
   input wire regRd,
   input wire [31:0] regRdData,
   input wire [23:0] discAddr,
   input wire discRead,
   input wire [31:0] discData,
   input wire discValid
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_read_idle_zero:
   assert property (ce && !regRd |=> regRdData == 32'h0)
      else $error("read data not zero when idle");
   chk_unmapped_read: assert property (
      ce && regRd && regAddr == 8'h40 |=> regRdData == 32'h0)
      else $error("unmapped read not zero");
   chk_count_field: assert property (ce && regRd && regAddr == 8'h10 |=>
      regRdData[31:16] == 16'h0 && regRdData[15:8] ==
      (regRdData[7:0] == 8'h0 ? 8'h0 : regRdData[7:0] - 8'h1))
      else $error("header count field wrong");
   chk_disc_answer: assert property (ce && discRead |=> discValid)
      else $error("discovery read not answered");
   chk_disc_idle: assert property (
      ce && !discRead |=> !discValid && discData == 32'h0)
      else $error("discovery output not idle");
   chk_below_first: assert property (
      ce && discRead && discAddr < 24'h8 |=> discData == 32'h0)
      else $error("data below first header");
   chk_word0_fields: assert property (
      ce && discRead && !discAddr[2] ##1 discData != 32'h0 |->
      discData[31:24] != 8'h0 && discData[23:16] != 8'h0)
      else $error("zero length or major served");
   chk_word1_fields: assert property (
      ce && discRead && discAddr[2] ##1 discData != 32'h0 |->
      discData[31:24] != 8'h0 && discData[1:0] == 2'h0)
      else $error("bad id high byte or pointer");
endmodule

bind phd_header_store phd_asserts i_phd_asserts (
   .clk(clk),
   .reset(reset),
   .ce(ce),
   .regAddr(regAddr),
   .regRd(regRd),
   .regRdData(regRdData),
   .discAddr(discAddr),
   .discRead(discRead),
   .discData(discData),
   .discValid(discValid)
);

// ===== tb/phd_host_model.sv
/*
 Host reader of the discovery headers, with its id classifier.
 Assumes the device answers on the clk domain.
*/
`timescale 1ns/10ps
module phd_host_model (
   input wire clk,
   output logic [23:0] discAddr,
   output logic discRead,
   input wire [31:0] discData,
   input wire discValid
);
   initial begin
      discAddr = 24'hffffff;
      discRead = 1'b0;
   end
   task fetch(input [23:0] a, output [31:0] d, output ok);
      integer n;
      begin
         ok = 1'b0;
         d = 32'h0;
         @(posedge clk);
         discAddr <= a;
         discRead <= 1'b1;
         @(posedge clk);
         discRead <= 1'b0;
         discAddr <= ~a;
         for (n = 0; n < 4 && !ok; n = n + 1) begin
            #1;
            ok = discValid === 1'b1;
            d = discData;
            if (!ok)
               @(posedge clk);
         end
      end
   endtask
   // 0 basic, 1 vendor, 2 vendor function, 3 standard function, 7 bad
   function [2:0] classify(input [31:0] w0, input [31:0] w1);
      begin
         if (w1[1:0] != 2'h0 || w0[23:16] == 8'h0)
            classify = 3'h7;
         else if (w0[7:0] == 8'h0)
            classify = 3'h0;
         else if (w1[31:24] == 8'h0)
            classify = 3'h7;
         else if (!w1[31])
            classify = ^w0[7:0] ? 3'h1 : 3'h2;
         else
            classify = ^w0[7:0] ? 3'h7 : 3'h3;
      end
   endfunction
endmodule

// ===== tb/tb_flash_param_header_decoder.sv
/*
 Self-checking bench for phd_header_store with the host model.
 Assumes a 50 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module tb_flash_param_header_decoder;
   logic clk, reset, ce, regWr, regRd, irq;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, discData, d0, d1;
   logic [23:0] discAddr;
   logic discRead, discValid;
   integer failCount, comparisons, i;
   localparam [159:0] BAD0 = {32'h10010600, 32'h10010601,
      32'h10010684, 32'h10000684, 32'h00010684};
   localparam [159:0] BAD1 = {32'h01000100, 32'h80000100,
      32'hff000102, 32'hff000100, 32'hff000100};
   phd_header_store #(.IDX_W(2)) i_phd_header_store (.clk(clk),
      .reset(reset), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .discAddr(discAddr), .discRead(discRead), .discData(discData),
      .discValid(discValid), .irq(irq));
   phd_host_model i_phd_host_model (.clk(clk), .discAddr(discAddr),
      .discRead(discRead), .discData(discData), .discValid(discValid));
   task finalReport;
      begin
         if (failCount == 0 && comparisons > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task check(input [95:0] what, input [31:0] exp, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            failCount = failCount + 1;
            $display("[FAIL] %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         regAddr <= a;
         regWrData <= d;
         regWr <= 1'b1;
         @(posedge clk);
         regWr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clk);
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge clk);
         regRd <= 1'b0;
         #1;
         check("register", exp, regRdData);
      end
   endtask
   task hdr(input [31:0] idx, w0, w1, st);
      begin
         wr(8'h04, idx);
         wr(8'h08, w0);
         wr(8'h0c, w1);
         rd(8'h14, st);
      end
   endtask
   task disc(input [23:0] a, input [31:0] exp, output [31:0] d);
      logic ok;
      begin
         i_phd_host_model.fetch(a, d, ok);
         if (!ok) begin
            failCount = failCount + 1;
            finalReport;
         end
         check("disc word", exp, d);
      end
   endtask
   task basicHeader;
      begin
         rd(8'h18, 32'h0);
         rd(8'h00, 32'h0);
         wr(8'h18, 32'h1f);
         wr(8'h00, 32'h1);
         wr(8'h04, 32'h0);
         wr(8'h08, 32'h10010600);
         wr(8'h0c, 32'hff000010);
         @(posedge clk);
         #1;
         check("irq set", 32'h1, {31'h0, irq});
         rd(8'h14, 32'h1);
         @(posedge clk);
         #1;
         check("irq clear", 32'h0, {31'h0, irq});
         rd(8'h10, 32'h1);
         disc(24'h8, 32'h10010600, d0);
         disc(24'hc, 32'hff000010, d1);
         check("class", 32'h0, i_phd_host_model.classify(d0, d1));
         disc(24'h10, 32'h0, d1);
         rd(8'h14, 32'h10);
      end
   endtask
   task badHeaders;
      begin
         for (i = 0; i < 5; i = i + 1)
            hdr(1, BAD0[32*i +: 32], BAD1[32*i +: 32], 32'h2);
         rd(8'h10, 32'h1);
      end
   endtask
   task orderAndGap;
      begin
         wr(8'h18, 32'h0);
         hdr(1, 32'h09010000, 32'hff000100, 32'h4);
         check("irq masked", 32'h0, {31'h0, irq});
         hdr(1, 32'h11010700, 32'hff000010, 32'h1);
         hdr(3, 32'h02010084, 32'h01000080, 32'h8);
         hdr(2, 32'h02010084, 32'h01000080, 32'h1);
         rd(8'h10, 32'h203);
         disc(24'h18, 32'h02010084, d0);
         disc(24'h1c, 32'h01000080, d1);
         check("class", 32'h2, i_phd_host_model.classify(d0, d1));
      end
   endtask
   task wipeFirst;
      begin
         wr(8'h00, 32'h3);
         rd(8'h00, 32'h1);
         rd(8'h10, 32'h0);
         hdr(0, 32'h02010084, 32'h01000080, 32'h2);
         rd(8'h40, 32'h0);
         disc(24'h8, 32'h0, d0);
      end
   endtask
   task cePause;
      begin
         @(posedge clk);
         ce <= 1'b0;
         wr(8'h18, 32'h1f);
         ce <= 1'b1;
         rd(8'h18, 32'h0);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      failCount = 0;
      comparisons = 0;
      reset = 1'b1;
      ce = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h0;
      regWrData = 32'h0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      basicHeader;
      badHeaders;
      orderAndGap;
      wipeFirst;
      cePause;
      finalReport;
   end
endmodule
